// *** src/ocf_fault_ctrl.sv ***
/*
 * Output over-current and short-circuit fault response: limit registers,
 * response modes, timed restart attempts and status flags.
 * Assumes current_sense comes from the ADC path on clk, fast_trip from an
 * asynchronous comparator pin, and control levels from same-clock logic.
 */
// Function
// - Retry code 6: six restarts, then output stays off until fault clear.
// - Retry code 7: restart forever until commanded off, bias lost, other fault.
// - Delay field counts 2**code units, 1 to 128.
// - Delay count times fault ride-through or restart spacing, unit from input.
// - Over-current limit is 16-bit read/write and sets the detection threshold.
// - Every mode sets the matching status flag and raises the host alert.
// - Mode 00 keeps running indefinitely while limiting at the over-current limit.
// - Mode 10 limits at fast limit for the delay, then shuts down and retries.
// - Retry code 0: no restart; output off until fault clear.
// - Retry codes 1 and 2: one or two restarts, then off until fault clear.
// - Restart attempt starts are spaced by delay count times delay unit.
// - Delay unit codes 0..3 select 1, 4, 16 or 256 ms.
`timescale 1ns/1ps
module ocf_fault_ctrl #(
   parameter int UNIT_CYC = ocf_pkg::BASE_UNIT_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire ocf_pkg::ocf_cmd_s    cmd,
   output ocf_pkg::ocf_rsp_s         rsp,
   input  wire logic [15:0]          current_sense,
   input  wire logic                 fast_trip,
   input  wire logic                 enable_cmd,
   input  wire logic                 bias_ok,
   input  wire logic                 other_fault,
   input  wire logic                 fault_clear,
   input  wire logic [1:0]           delay_unit,
   output logic                      out_enable,
   output logic                      current_limit_active,
   output logic                      fast_limit_select,
   output ocf_pkg::ocf_status_s      status
);
   typedef struct packed {
      ocf_pkg::ocf_state_e  st;
      logic [15:0]          oc_lim;
      logic [7:0]           resp;
      logic [2:0]           attempts;
      logic                 tstart;
      logic                 trip_s1;
      logic                 trip_s2;
      logic                 oc_over;
      logic                 out_en;
      logic                 cl_act;
      logic                 lim_sel;
      logic                 oc_flag;
      logic                 sc_flag;
      logic                 alert;
      logic                 latched;
      logic                 retry;
      ocf_pkg::ocf_rsp_s    rsp;
   } ocf_ctrl_s;

   ocf_ctrl_s  s;
   ocf_ctrl_s  n;
   logic       t_done;
   logic       fault;
   logic       on_ok;
   logic [1:0] mode;
   logic [2:0] retries;

   ocf_delay_timer #(
      .UNIT_CYC  (UNIT_CYC)
   ) u_timer (
      .clk       (clk),
      .rst_n     (rst_n),
      .start     (s.tstart),
      .dly_code  (s.resp[ocf_pkg::DLY_HI:ocf_pkg::DLY_LO]),
      .unit_code (delay_unit),
      .done      (t_done)
   );

   assign mode    = s.resp[ocf_pkg::MODE_HI:ocf_pkg::MODE_LO];
   assign retries = s.resp[ocf_pkg::RETRY_HI:ocf_pkg::RETRY_LO];
   assign fault   = s.oc_over | s.trip_s2;
   assign on_ok   = enable_cmd & bias_ok & ~other_fault;

   always_comb begin
      n = s;
      n.tstart    = 1'b0;
      n.rsp.valid = 1'b0;
      n.trip_s1   = fast_trip;
      n.trip_s2   = s.trip_s1;
      n.oc_over   = current_sense > s.oc_lim;

      // Set wins over a clear in the same cycle
      if (fault_clear) begin
         n.oc_flag = 1'b0;
         n.sc_flag = 1'b0;
      end
      if (s.oc_over) begin
         n.oc_flag = 1'b1;
      end
      if (s.trip_s2) begin
         n.sc_flag = 1'b1;
      end
      n.alert = n.oc_flag | n.sc_flag;

      if (cmd.valid) begin
         if (cmd.write) begin
            if (cmd.code == ocf_pkg::CMD_OC_LIMIT) begin
               n.oc_lim = cmd.wdata;
            end else if (cmd.code == ocf_pkg::CMD_SC_RESP) begin
               n.resp = cmd.wdata[7:0];
            end
         end else begin
            n.rsp.valid = 1'b1;
            n.rsp.unsup = 1'b0;
            if (cmd.code == ocf_pkg::CMD_OC_LIMIT) begin
               n.rsp.data = s.oc_lim;
            end else if (cmd.code == ocf_pkg::CMD_SC_RESP) begin
               n.rsp.data = {8'h00, s.resp};
            end else begin
               n.rsp.data  = 16'h0000;
               n.rsp.unsup = 1'b1;
            end
         end
      end

      if (!on_ok) begin
         // Commanded off, bias lost or another fault ends any sequence
         n.st       = ocf_pkg::ST_OFF;
         n.attempts = 3'h0;
         n.out_en   = 1'b0;
         n.cl_act   = 1'b0;
         n.lim_sel  = 1'b0;
      end else begin
         case (s.st)
            ocf_pkg::ST_OFF: begin
               n.st     = ocf_pkg::ST_RUN;
               n.out_en = 1'b1;
            end
            ocf_pkg::ST_RUN: begin
               n.out_en = 1'b1;
               if (fault) begin
                  if (mode == ocf_pkg::MODE_DLY_RETRY) begin
                     n.st      = ocf_pkg::ST_DELAY;
                     n.tstart  = 1'b1;
                     n.cl_act  = 1'b1;
                     n.lim_sel = 1'b1;
                  end else if (mode == ocf_pkg::MODE_HOLD_OFF) begin
                     n.st     = ocf_pkg::ST_HOLD;
                     n.out_en = 1'b0;
                  end else begin
                     n.st     = ocf_pkg::ST_LIMIT;
                     n.cl_act = 1'b1;
                  end
               end
            end
            ocf_pkg::ST_LIMIT: begin
               // Brickwall limiting never times out
               if (!fault) begin
                  n.st     = ocf_pkg::ST_RUN;
                  n.cl_act = 1'b0;
               end
            end
            ocf_pkg::ST_DELAY: begin
               if (!fault) begin
                  n.st      = ocf_pkg::ST_RUN;
                  n.cl_act  = 1'b0;
                  n.lim_sel = 1'b0;
               end else if (t_done) begin
                  n.out_en  = 1'b0;
                  n.cl_act  = 1'b0;
                  n.lim_sel = 1'b0;
                  if (retries == ocf_pkg::RETRY_NONE) begin
                     n.st = ocf_pkg::ST_LATCHED;
                  end else begin
                     n.st     = ocf_pkg::ST_WAIT;
                     n.tstart = 1'b1;
                  end
               end
            end
            ocf_pkg::ST_HOLD: begin
               if (!fault) begin
                  n.st     = ocf_pkg::ST_RUN;
                  n.out_en = 1'b1;
               end
            end
            ocf_pkg::ST_WAIT: begin
               n.out_en = 1'b0;
               if (t_done) begin
                  if (retries == ocf_pkg::RETRY_FOREVER) begin
                     n.st     = ocf_pkg::ST_TRY;
                     n.out_en = 1'b1;
                     n.tstart = 1'b1;
                  end else if (s.attempts < retries) begin
                     n.st       = ocf_pkg::ST_TRY;
                     n.out_en   = 1'b1;
                     n.tstart   = 1'b1;
                     n.attempts = s.attempts + 3'h1;
                  end else begin
                     n.st = ocf_pkg::ST_LATCHED;
                  end
               end
            end
            ocf_pkg::ST_TRY: begin
               // A failed attempt stays off until its spacing period ends
               if (fault) begin
                  n.st     = ocf_pkg::ST_WAIT;
                  n.out_en = 1'b0;
               end else if (t_done) begin
                  n.st       = ocf_pkg::ST_RUN;
                  n.attempts = 3'h0;
               end
            end
            default: begin
               n.out_en = 1'b0;
               if (fault_clear) begin
                  n.st       = ocf_pkg::ST_RUN;
                  n.out_en   = 1'b1;
                  n.attempts = 3'h0;
               end
            end
         endcase
      end
      n.latched = (n.st == ocf_pkg::ST_LATCHED);
      n.retry   = (n.st == ocf_pkg::ST_WAIT) | (n.st == ocf_pkg::ST_TRY);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s        <= '0;
         s.oc_lim <= ocf_pkg::OC_LIMIT_RST;
         s.resp   <= ocf_pkg::SC_RESP_RST;
      end else begin
         s <= n;
      end
   end

   assign rsp                  = s.rsp;
   assign out_enable           = s.out_en;
   assign current_limit_active = s.cl_act;
   assign fast_limit_select    = s.lim_sel;
   assign status = '{oc_fault: s.oc_flag, sc_fault: s.sc_flag, alert: s.alert,
                     latched_off: s.latched, retrying: s.retry, attempts: s.attempts};

   a_six_then_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_WAIT && t_done && on_ok && retries == 3'h6
       && s.attempts == 3'h6) |=> s.st == ocf_pkg::ST_LATCHED && !out_enable)
      else $error("sixth failed attempt did not latch off");

   a_endless_retry: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_WAIT && t_done && on_ok && retries == 3'h7)
      |=> out_enable && s.st == ocf_pkg::ST_TRY)
      else $error("continuous retry stopped");

   a_limit_threshold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (current_sense > s.oc_lim && !$past(cmd.valid)) |=> s.oc_over)
      else $error("over-current not detected against limit");

   a_fault_flag_set: assert property (
      @(posedge clk) disable iff (!rst_n)
      s.trip_s2 |=> status.sc_fault && status.alert)
      else $error("short-circuit flag or alert missing");

   a_ignore_keeps_on: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_RUN && on_ok && fault && mode == ocf_pkg::MODE_IGNORE)
      |=> current_limit_active && !fast_limit_select && out_enable)
      else $error("ignore mode did not limit while running");

   a_fast_limit_delay: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_DELAY) |-> fast_limit_select && current_limit_active && out_enable)
      else $error("delay phase not limiting at fast limit");

   a_no_retry_latch: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_DELAY && fault && t_done && on_ok && retries == 3'h0)
      |=> s.st == ocf_pkg::ST_LATCHED && !out_enable)
      else $error("zero retries did not latch off");

   a_retry_bound: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s.st == ocf_pkg::ST_LATCHED && on_ok && !fault_clear) |=> !out_enable)
      else $error("latched output came back without fault clear");

   a_count_clears: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!on_ok || (s.st == ocf_pkg::ST_TRY && !fault && t_done)) |=> status.attempts == 3'h0)
      else $error("attempt counter not cleared");

endmodule

// *** src/ocf_pkg.sv ***
/*
 * Shared constants and carrier types for the output current fault block.
 * Assumes a 125 MHz controller clock and an upstream command decoder that
 * hands over one command byte with its data word per transfer.
 */
package ocf_pkg;

   // Command codes of the two configuration registers
   localparam logic [7:0]  CMD_OC_LIMIT   = 8'hB9;
   localparam logic [7:0]  CMD_SC_RESP    = 8'hBA;

   // Reset contents
   localparam logic [15:0] OC_LIMIT_RST   = 16'hFFFF;
   localparam logic [7:0]  SC_RESP_RST    = 8'h80;

   // Response byte fields
   localparam int          MODE_HI        = 7;
   localparam int          MODE_LO        = 6;
   localparam int          RETRY_HI       = 5;
   localparam int          RETRY_LO       = 3;
   localparam int          DLY_HI         = 2;
   localparam int          DLY_LO         = 0;

   // Response modes and retry codes
   localparam logic [1:0]  MODE_IGNORE    = 2'h0;
   localparam logic [1:0]  MODE_DLY_RETRY = 2'h2;
   localparam logic [1:0]  MODE_HOLD_OFF  = 2'h3;
   localparam logic [2:0]  RETRY_NONE     = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER  = 3'h7;

   // Delay unit timing: base unit and per-code scale (1, 4, 16, 256 ms)
   localparam int          CLK_PERIOD_NS  = 8;
   localparam int          UNIT_BASE_NS   = 1000000;
   localparam int          BASE_UNIT_CYC  = UNIT_BASE_NS / CLK_PERIOD_NS;
   localparam int          UNIT_MS_0      = 1;
   localparam int          UNIT_MS_1      = 4;
   localparam int          UNIT_MS_2      = 16;
   localparam int          UNIT_MS_3      = 256;

   typedef enum logic [2:0] {
      ST_OFF, ST_RUN, ST_LIMIT, ST_DELAY, ST_HOLD, ST_WAIT, ST_TRY, ST_LATCHED
   } ocf_state_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } ocf_cmd_s;

   typedef struct packed {
      logic        valid;
      logic        unsup;
      logic [15:0] data;
   } ocf_rsp_s;

   typedef struct packed {
      logic        oc_fault;
      logic        sc_fault;
      logic        alert;
      logic        latched_off;
      logic        retrying;
      logic [2:0]  attempts;
   } ocf_status_s;

endpackage

// *** src/ocf_delay_timer.sv ***
/*
 * Delay timer: counts 2**code delay units, each unit a base period scaled
 * by the two-bit unit select. Assumes a one-cycle start pulse from logic on
 * the same clock; settings are captured at start.
 */
`timescale 1ns/1ps
module ocf_delay_timer #(
   parameter int UNIT_CYC = ocf_pkg::BASE_UNIT_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic [2:0] dly_code,
   input  wire logic [1:0] unit_code,
   output logic            done
);
   typedef struct packed {
      logic        busy;
      logic        done;
      logic [2:0]  dly;
      logic [1:0]  unit;
      logic [31:0] pre;
      logic [7:0]  units;
   } ocf_tmr_s;

   ocf_tmr_s   s;
   ocf_tmr_s   n;
   logic [3:0] shift;
   logic [31:0] unit_max;
   logic [7:0]  unit_tgt;

   always_comb begin
      n = s;
      n.done = 1'b0;
      case (s.unit)
         2'h0:    shift = 4'h0;
         2'h1:    shift = 4'h2;
         2'h2:    shift = 4'h4;
         default: shift = 4'h8;
      endcase
      unit_max = (32'(UNIT_CYC) << shift) - 32'h1;
      unit_tgt = 8'((9'h1 << s.dly) - 9'h1);
      if (start) begin
         n.busy  = 1'b1;
         n.dly   = dly_code;
         n.unit  = unit_code;
         n.pre   = 32'h0;
         n.units = 8'h0;
      end else if (s.busy) begin
         if (s.pre == unit_max) begin
            n.pre = 32'h0;
            if (s.units == unit_tgt) begin
               n.busy = 1'b0;
               n.done = 1'b1;
            end else begin
               n.units = s.units + 8'h1;
            end
         end else begin
            n.pre = s.pre + 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign done = s.done;

   // Independent elapsed-time check against the millisecond table
   logic [31:0] elapsed_ff;
   logic [31:0] unit_ms;
   always_comb begin
      case (s.unit)
         2'h0:    unit_ms = 32'(ocf_pkg::UNIT_MS_0);
         2'h1:    unit_ms = 32'(ocf_pkg::UNIT_MS_1);
         2'h2:    unit_ms = 32'(ocf_pkg::UNIT_MS_2);
         default: unit_ms = 32'(ocf_pkg::UNIT_MS_3);
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_ff <= 32'h0;
      end else if (start) begin
         elapsed_ff <= 32'h0;
      end else if (s.busy) begin
         elapsed_ff <= elapsed_ff + 32'h1;
      end
   end

   a_delay_length: assert property (
      @(posedge clk) disable iff (!rst_n)
      s.done |-> elapsed_ff == 32'(UNIT_CYC) * unit_ms * (32'h1 << s.dly))
      else $error("delay length does not match code and unit");

endmodule

// *** tb/ocf_host_model.sv ***
/*
 * Behavioural system management host on the command port of the fault block.
 * Assumes the bench calls its write and read tasks from one process on clk.
 */
`timescale 1ns/1ps
module ocf_host_model (
   input  wire logic              clk,
   input  wire logic              rst_n,
   output ocf_pkg::ocf_cmd_s      cmd,
   input  wire ocf_pkg::ocf_rsp_s rsp
);
   initial begin
      cmd = '0;
   end

   // Idle fields show the inverse so stale values cannot pass for a match
   task automatic release_cmd();
      cmd.valid <= 1'b0;
      cmd.code  <= ~cmd.code;
      cmd.wdata <= ~cmd.wdata;
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      wait (rst_n === 1'b1);
      @(posedge clk);
      cmd <= '{valid: 1'b1, write: 1'b1, code: code, wdata: data};
      @(posedge clk);
      release_cmd();
   endtask

   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic unsup);
      int n;
      n = 0;
      wait (rst_n === 1'b1);
      @(posedge clk);
      cmd <= '{valid: 1'b1, write: 1'b0, code: code, wdata: cmd.wdata};
      @(posedge clk);
      release_cmd();
      @(posedge clk);
      while (rsp.valid !== 1'b1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      data  = rsp.data;
      unsup = rsp.unsup;
   endtask
endmodule

// *** tb/ocf_fault_ctrl_test.sv ***
/*
 * Self-checking bench of the fault response block with a host model.
 * Assumes a shortened base unit of UC cycles per 1 ms.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); error_cnt++; end end
module ocf_fault_ctrl_test;
   localparam int UC = 4;
   logic                 clk;
   logic                 rst_n;
   ocf_pkg::ocf_cmd_s    cmd;
   ocf_pkg::ocf_rsp_s    rsp;
   logic [15:0]          current_sense;
   logic                 fast_trip;
   logic                 enable_cmd;
   logic                 bias_ok;
   logic                 other_fault;
   logic                 fault_clear;
   logic [1:0]           delay_unit;
   logic                 out_enable;
   logic                 current_limit_active;
   logic                 fast_limit_select;
   ocf_pkg::ocf_status_s status;
   int                   error_cnt;
   int                   checked;
   logic [31:0]          rnd;
   logic [15:0]          rdat;
   logic                 runs;

   ocf_fault_ctrl #(.UNIT_CYC(UC)) i_ocf_fault_ctrl (
      .clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .current_sense(current_sense),
      .fast_trip(fast_trip), .enable_cmd(enable_cmd), .bias_ok(bias_ok),
      .other_fault(other_fault), .fault_clear(fault_clear), .delay_unit(delay_unit),
      .out_enable(out_enable), .current_limit_active(current_limit_active),
      .fast_limit_select(fast_limit_select), .status(status));

   ocf_host_model i_ocf_host_model (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
   endfunction

   // Delay period in cycles: 2**code units of 1/4/16/256 base units
   function automatic int dly(input int code, input int unit);
      int ms;
      ms = (unit == 0) ? 1 : (unit == 1) ? 4 : (unit == 2) ? 16 : 256;
      return UC * ms * (1 << code);
   endfunction

   task automatic final_report();
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_oe(input logic v, input int lim, output int n);
      n = 0;
      while (out_enable !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic wr_resp(input logic [7:0] b);
      i_ocf_host_model.wr(ocf_pkg::CMD_SC_RESP, {8'h00, b});
   endtask

   task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic uns);
      logic [15:0] d;
      logic        u;
      i_ocf_host_model.rd(code, d, u);
      `CHK("read data", exp, d)
      `CHK("unsupported flag", uns, u)
   endtask

   task automatic clear_fault();
      int n;
      current_sense <= 16'h0000;
      fast_trip     <= 1'b0;
      tick(4);
      fault_clear <= 1'b1;
      tick(1);
      fault_clear <= 1'b0;
      wait_oe(1'b1, 60, n);
      tick(2);
      `CHK("flag after clear", 1'b0, status.alert)
   endtask

   initial begin
      #(8 * 95000);
      error_cnt++;
      final_report();
   end

   initial begin
      int n;
      int d;
      int code;
      int unit;
      int cnt;
      int last;
      logic prev;
      logic seen;
      logic [15:0] lim;
      logic [2:0] rtab [4];
      rtab = '{3'h0, 3'h1, 3'h2, 3'h6};
      error_cnt = 0;
      checked = 0;
      rnd = 32'h12884e93;
      rst_n = 1'b0;
      current_sense = 16'h0000;
      fast_trip = 1'b0;
      enable_cmd = 1'b1;
      bias_ok = 1'b1;
      other_fault = 1'b0;
      fault_clear = 1'b0;
      delay_unit = 2'h0;
      tick(10);
      rst_n <= 1'b1;
      tick(3);
      rd_chk(ocf_pkg::CMD_OC_LIMIT, ocf_pkg::OC_LIMIT_RST, 1'b0);
      rd_chk(ocf_pkg::CMD_SC_RESP, {8'h00, ocf_pkg::SC_RESP_RST}, 1'b0);
      rd_chk(8'hC8, 16'h0000, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         i_ocf_host_model.wr(ocf_pkg::CMD_OC_LIMIT, rnd[15:0]);
         wr_resp(rnd[23:16]);
         rd_chk(ocf_pkg::CMD_OC_LIMIT, rnd[15:0], 1'b0);
         rd_chk(ocf_pkg::CMD_SC_RESP, {8'h00, rnd[23:16]}, 1'b0);
      end
      // Modes 00 and 01: threshold exact, limiting without shutdown
      for (int m = 0; m < 2; m++) begin
         rnd = lfsr(rnd);
         lim = {1'b0, rnd[14:0]};
         i_ocf_host_model.wr(ocf_pkg::CMD_OC_LIMIT, lim);
         wr_resp({m[1:0], 6'h00});
         current_sense <= lim;
         tick(10);
         `CHK("limit at threshold", 1'b0, current_limit_active)
         current_sense <= lim + 16'h0001;
         tick(10);
         `CHK("limit above threshold", 1'b1, current_limit_active)
         `CHK("oc flag", 1'b1, status.oc_fault)
         `CHK("alert", 1'b1, status.alert)
         tick(200);
         `CHK("output kept on", 1'b1, out_enable)
         `CHK("still limiting", 1'b1, current_limit_active)
         clear_fault();
      end
      wr_resp(8'hC0);
      fast_trip <= 1'b1;
      tick(10);
      `CHK("mode 11 off", 1'b0, out_enable)
      `CHK("sc flag", 1'b1, status.sc_fault)
      fast_trip <= 1'b0;
      tick(10);
      `CHK("mode 11 resume", 1'b1, out_enable)
      clear_fault();
      // Ride-through time over every delay code and every unit code
      for (int i = 0; i < 11; i++) begin
         code = (i < 8) ? i : 0;
         unit = (i < 8) ? 0 : i - 7;
         d = dly(code, unit);
         wr_resp({2'b10, 3'b000, code[2:0]});
         delay_unit <= unit[1:0];
         fast_trip <= 1'b1;
         seen = 1'b0;
         n = 0;
         while (out_enable !== 1'b0 && n < d + 40) begin
            @(posedge clk);
            seen = seen | (fast_limit_select === 1'b1);
            n++;
         end
         `CHK("ride-through length", 1'b1, (n >= d && n <= d + 8))
         `CHK("fast limit used", 1'b1, seen)
         tick(3 * d);
         `CHK("no retry stays off", 1'b0, out_enable)
         `CHK("latched", 1'b1, status.latched_off)
         clear_fault();
      end
      // Later spacing figures assume the 1 ms unit again
      delay_unit <= 2'h0;
      // Retry counts and spacing; endless retry ended by bias, command, other fault
      for (int k = 0; k < 7; k++) begin
         rnd = lfsr(rnd);
         code = rnd[0];
         d = dly(code, 0);
         wr_resp({2'b10, (k < 4) ? rtab[k] : 3'h7, code[2:0]});
         fast_trip <= 1'b1;
         cnt = 0;
         n = 0;
         last = 0;
         prev = 1'b1;
         runs = 1'b1;
         while (runs && n < 12 * (d + 12) + 100) begin
            @(posedge clk);
            n++;
            if (prev === 1'b0 && out_enable === 1'b1) begin
               if (cnt > 0) begin
                  `CHK("attempt spacing", 1'b1, (n - last >= d && n - last <= d + 8))
               end
               cnt++;
               last = n;
            end
            prev = out_enable;
            runs = (k < 4) ? (status.latched_off !== 1'b1) : (cnt < 9);
         end
         if (k < 4) begin
            `CHK("attempt count", int'(rtab[k]), cnt)
            `CHK("off after retries", 1'b0, out_enable)
         end else begin
            `CHK("endless retry", 9, cnt)
            bias_ok     <= (k != 4);
            enable_cmd  <= (k != 5);
            other_fault <= (k == 6);
            tick(4);
            `CHK("stop turns off", 1'b0, out_enable)
            `CHK("attempts cleared", 3'h0, status.attempts)
            `CHK("retry flag after stop", 1'b0, status.retrying)
            bias_ok     <= 1'b1;
            enable_cmd  <= 1'b1;
            other_fault <= 1'b0;
         end
         clear_fault();
      end
      // Fault removed during the first attempt: that attempt fails, the second restart succeeds
      d = dly(1, 0);
      wr_resp({2'b10, 3'h2, 3'h1});
      fast_trip <= 1'b1;
      wait_oe(1'b0, d + 40, n);
      wait_oe(1'b1, d + 40, n);
      `CHK("retrying during attempt", 1'b1, status.retrying)
      fast_trip <= 1'b0;
      tick(3 * d + 10);
      `CHK("restart kept", 1'b1, out_enable)
      `CHK("attempts reset", 3'h0, status.attempts)
      `CHK("not latched", 1'b0, status.latched_off)
      `CHK("retrying over", 1'b0, status.retrying)
      clear_fault();
      final_report();
   end
endmodule
